// *** src/cmp_pkg.sv ***
// Shared constants and carrier types for the comparator control block
package cmp_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] CFG_A_OFFSET    = 8'h00;
    localparam logic [7:0] CFG_B_OFFSET    = 8'h04;
    localparam logic [7:0] REF_CTRL_OFFSET = 8'h08;

    // Reset values
    localparam logic [7:0] CFG_A_RESET = 8'h00;
    localparam logic [7:0] CFG_B_RESET = 8'h02;
    localparam logic [7:0] REF_RESET   = 8'h00;

    // Writable bit masks
    localparam logic [7:0] CFG_A_WMASK = 8'h1F;
    localparam logic [7:0] CFG_B_WMASK = 8'h03;
    localparam logic [7:0] REF_WMASK   = 8'hAF;

    // Field positions
    localparam int CFG_A_OUT_BIT   = 6;
    localparam int CFG_A_INV_BIT   = 4;
    localparam int CFG_A_SW_BIT    = 3;
    localparam int CFG_A_MODE_LSB  = 0;
    localparam int CFG_B_GATE_BIT  = 1;
    localparam int CFG_B_SYNC_BIT  = 0;
    localparam int REF_EN_BIT      = 7;
    localparam int REF_RANGE_BIT   = 5;
    localparam int REF_LEVEL_LSB   = 0;

    // Timer clock edges are ignored until the filter and edge history have filled
    localparam logic [2:0] SYNC_SETTLE = 3'h5;

    // Reference tap arithmetic, in 1/96 of the supply
    localparam logic [6:0] REF_DENOM     = 7'h60;
    localparam logic [6:0] REF_LOW_STEP  = 7'h04;
    localparam logic [6:0] REF_HIGH_STEP = 7'h03;
    localparam logic [6:0] REF_HIGH_BASE = 7'h18;

    // Comparator mode and input settings
    typedef struct packed {
        logic       invert;
        logic       input_switch;
        logic [2:0] mode;
    } cmp_cfg_t;

    // Timer gate and sync controls
    typedef struct packed {
        logic timer_gate_source_select;
        logic comparator_sync_select;
    } gate_cfg_t;

    // Reference ladder controls
    typedef struct packed {
        logic       reference_enable;
        logic       reference_range_select;
        logic [3:0] reference_level;
    } ref_cfg_t;

    // Merge a bus write into a register under its writable mask
    function automatic logic [7:0] masked_write(input logic [7:0] old_val,
                                                input logic [7:0] wdata,
                                                input logic [7:0] wmask);
        masked_write = (old_val & ~wmask) | (wdata & wmask);
    endfunction

endpackage

// *** src/input_sync.sv ***
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module input_sync (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Asynchronous input and filtered level
    input  wire logic async_in,
    output logic      level
);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    // Stage one feeds stage two only; agreement filter sits on stages two and three
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_r <= 1'b0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end

    assign level = level_r;

endmodule

// *** src/reference_ladder_ctrl.sv ***
// Reference ladder power and tap selection from the reference control fields
`timescale 1ns/1ps
module reference_ladder_ctrl (
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // Control fields
    input  wire cmp_pkg::ref_cfg_t ref_cfg,
    // Ladder drive
    output logic                   ladder_power,
    output logic [6:0]             reference_code
);

    logic [6:0] code_low;
    logic [6:0] code_high;
    logic [6:0] code_nxt;
    logic       ladder_power_r;
    logic [6:0] reference_code_r;

    // Tap value in 1/96 of supply: low range level/24, high range 1/4 + level/32
    assign code_low  = 7'(ref_cfg.reference_level) * cmp_pkg::REF_LOW_STEP;
    assign code_high = cmp_pkg::REF_HIGH_BASE
                     + 7'(ref_cfg.reference_level) * cmp_pkg::REF_HIGH_STEP;
    // Disabled ladder clamps to ground and draws nothing
    assign code_nxt  = !ref_cfg.reference_enable ? 7'h00 :
                       ref_cfg.reference_range_select ? code_low : code_high;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ladder_power_r   <= 1'b0;
            reference_code_r <= 7'h00;
        end else begin
            ladder_power_r   <= ref_cfg.reference_enable;
            reference_code_r <= code_nxt;
        end
    end

    assign ladder_power   = ladder_power_r;
    assign reference_code = reference_code_r;

    a_ref_off_ground: assert property (@(posedge hclk) disable iff (!hresetn)
        !ref_cfg.reference_enable |=> !ladder_power && reference_code == 7'h00)
        else $error("disabled ladder not at ground");

    a_ref_low_range: assert property (@(posedge hclk) disable iff (!hresetn)
        ref_cfg.reference_enable && ref_cfg.reference_range_select
        |=> reference_code == 7'($past(ref_cfg.reference_level)) * 7'h04)
        else $error("low range tap wrong");

endmodule

// *** src/comparator_sync_and_reference_ctrl.sv ***
// Comparator sync latch, timer gate routing and reference control behind AHB-Lite
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module comparator_sync_and_reference_ctrl (
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // Analog comparator
    input  wire logic              comparator_output,
    output cmp_pkg::cmp_cfg_t      comparator_cfg,
    // Reference ladder
    output logic                   ladder_power,
    output logic [6:0]             reference_code,
    // Sixteen-bit timer
    input  wire logic              timer_clk_raw,
    input  wire logic              timer_clk_prescaled,
    input  wire logic              timer_prescale_on,
    input  wire logic              timer_on,
    input  wire logic              timer_gate_enable,
    input  wire logic              timer_gate_pin,
    output logic                   timer_gate,
    output logic                   timer_count_enable,
    output logic                   timer_increment
);

    // Register state
    logic [7:0]         cfg_a_r;
    logic [7:0]         cfg_b_r;
    logic [7:0]         ref_r;

    // Bus data-phase state
    logic               dp_write_r;
    logic               dp_read_r;
    logic [7:0]         dp_addr_r;

    // Timing and latch state
    logic               tclk_prev_r;
    logic [2:0]         settle_r;
    logic               sync_latch_r;
    logic               count_en_r;
    logic               increment_r;

    // Field views
    cmp_pkg::gate_cfg_t gate_cfg;
    cmp_pkg::ref_cfg_t  ref_cfg;

    // Selected timer clock and synchronised levels
    logic               tclk_sel;
    logic               tclk_lvl;
    logic               cmp_lvl;
    logic               pin_lvl;

    // Decode and next values
    logic               addr_take;
    logic               wr_a;
    logic               wr_b;
    logic               wr_ref;
    logic [7:0]         rd_a;
    logic [7:0]         rd_byte;
    logic               edges_live;
    logic               tclk_fall;
    logic               tclk_rise;
    logic               cmp_gate_lvl;
    logic               gate_lvl;
    logic               count_en_nxt;
    logic [7:0]         cfg_a_nxt;
    logic [7:0]         cfg_b_nxt;
    logic [7:0]         ref_nxt;

    // Register fields, named by use
    assign gate_cfg.timer_gate_source_select = cfg_b_r[cmp_pkg::CFG_B_GATE_BIT];
    assign gate_cfg.comparator_sync_select   = cfg_b_r[cmp_pkg::CFG_B_SYNC_BIT];
    assign ref_cfg.reference_enable          = ref_r[cmp_pkg::REF_EN_BIT];
    assign ref_cfg.reference_range_select    = ref_r[cmp_pkg::REF_RANGE_BIT];
    assign ref_cfg.reference_level           = ref_r[cmp_pkg::REF_LEVEL_LSB +: 4];
    assign comparator_cfg.invert             = cfg_a_r[cmp_pkg::CFG_A_INV_BIT];
    assign comparator_cfg.input_switch       = cfg_a_r[cmp_pkg::CFG_A_SW_BIT];
    assign comparator_cfg.mode               = cfg_a_r[cmp_pkg::CFG_A_MODE_LSB +: 3];

    // Latch clock is the prescaled timer clock whenever the prescaler is in use
    assign tclk_sel = timer_prescale_on ? timer_clk_prescaled : timer_clk_raw;

    // Pin and foreign-clock inputs all cross through the agreement filter
    input_sync u_sync_tclk (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (tclk_sel),
        .level    (tclk_lvl)
    );

    input_sync u_sync_cmp (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (comparator_output),
        .level    (cmp_lvl)
    );

    input_sync u_sync_pin (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (timer_gate_pin),
        .level    (pin_lvl)
    );

    // Reference ladder sees only its own register, never the comparator mode
    reference_ladder_ctrl u_ladder (
        .hclk           (hclk),
        .hresetn        (hresetn),
        .ref_cfg        (ref_cfg),
        .ladder_power   (ladder_power),
        .reference_code (reference_code)
    );

    // Timer clock edges seen on the filtered level. The filter resets low, so a clock
    // idling high would look like a rise after reset; edges wait until history has filled.
    assign edges_live = (settle_r == cmp_pkg::SYNC_SETTLE);
    assign tclk_fall  = edges_live & tclk_prev_r & ~tclk_lvl;
    assign tclk_rise  = edges_live & ~tclk_prev_r & tclk_lvl;

    // Comparator gate level: latched copy with sync on, filtered level otherwise
    assign cmp_gate_lvl = gate_cfg.comparator_sync_select ? sync_latch_r : cmp_lvl;
    assign gate_lvl     = gate_cfg.timer_gate_source_select ? pin_lvl : cmp_gate_lvl;

    // Gating bites only while the timer runs with its gate function on
    assign count_en_nxt = timer_on & (~timer_gate_enable | gate_lvl);

    // Gate line to the timer; with sync off the comparator is not latched at all
    assign timer_gate = gate_cfg.timer_gate_source_select ? timer_gate_pin :
                        gate_cfg.comparator_sync_select ? sync_latch_r :
                        comparator_output;

    // Latch on falling edge, count on rising edge, so the value settles half a cycle first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tclk_prev_r  <= 1'b0;
            settle_r     <= 3'h0;
            sync_latch_r <= 1'b0;
            count_en_r   <= 1'b0;
            increment_r  <= 1'b0;
        end else begin
            tclk_prev_r <= tclk_lvl;
            if (!edges_live) begin
                settle_r <= settle_r + 3'h1;
            end
            if (gate_cfg.comparator_sync_select && tclk_fall) begin
                sync_latch_r <= cmp_lvl;
            end
            count_en_r  <= count_en_nxt;
            increment_r <= tclk_rise & count_en_nxt;
        end
    end

    assign timer_count_enable = count_en_r;
    assign timer_increment    = increment_r;

    // Zero-wait slave: takes an address phase whenever selected, ready and htrans[1] is set
    assign addr_take = hsel & htrans[1] & hready;
    assign wr_a      = dp_write_r & (dp_addr_r == cmp_pkg::CFG_A_OFFSET);
    assign wr_b      = dp_write_r & (dp_addr_r == cmp_pkg::CFG_B_OFFSET);
    assign wr_ref    = dp_write_r & (dp_addr_r == cmp_pkg::REF_CTRL_OFFSET);

    // Write merges, unimplemented bits kept at zero
    assign cfg_a_nxt = wr_a ? cmp_pkg::masked_write(cfg_a_r, hwdata[7:0], cmp_pkg::CFG_A_WMASK)
                            : cfg_a_r;
    assign cfg_b_nxt = wr_b ? cmp_pkg::masked_write(cfg_b_r, hwdata[7:0], cmp_pkg::CFG_B_WMASK)
                            : cfg_b_r;
    assign ref_nxt   = wr_ref ? cmp_pkg::masked_write(ref_r, hwdata[7:0], cmp_pkg::REF_WMASK)
                              : ref_r;

    // Config A shows the live comparator level in its status bit
    always_comb begin
        rd_a = cfg_a_r;
        rd_a[cmp_pkg::CFG_A_OUT_BIT] = cmp_lvl;
    end

    // Read mux; unmapped offsets read zero
    assign rd_byte = (dp_addr_r == cmp_pkg::CFG_A_OFFSET)    ? rd_a    :
                     (dp_addr_r == cmp_pkg::CFG_B_OFFSET)    ? cfg_b_r :
                     (dp_addr_r == cmp_pkg::REF_CTRL_OFFSET) ? ref_r   : 8'h00;

    // Data phase bookkeeping and register update
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_r <= 1'b0;
            dp_read_r  <= 1'b0;
            dp_addr_r  <= 8'h00;
            cfg_a_r    <= cmp_pkg::CFG_A_RESET;
            cfg_b_r    <= cmp_pkg::CFG_B_RESET;
            ref_r      <= cmp_pkg::REF_RESET;
        end else begin
            dp_write_r <= addr_take & hwrite;
            dp_read_r  <= addr_take & ~hwrite;
            if (addr_take) begin
                dp_addr_r <= {haddr[7:2], 2'b00};
            end
            cfg_a_r <= cfg_a_nxt;
            cfg_b_r <= cfg_b_nxt;
            ref_r   <= ref_nxt;
        end
    end

    // Never stalls and never errors; read data is a mux of flops
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = dp_read_r ? {24'h000000, rd_byte} : 32'h00000000;

    // Assertions
    a_latch_on_fall: assert property (@(posedge hclk) disable iff (!hresetn)
        gate_cfg.comparator_sync_select && tclk_fall
        |=> sync_latch_r == $past(cmp_lvl))
        else $error("latch missed falling edge");

    a_latch_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        !tclk_fall |=> $stable(sync_latch_r))
        else $error("latch moved without falling edge");

    a_prescale_clock: assert property (@(posedge hclk) disable iff (!hresetn)
        timer_prescale_on |-> tclk_sel == timer_clk_prescaled)
        else $error("latch not clocked by prescaled clock");

    a_incr_on_rise: assert property (@(posedge hclk) disable iff (!hresetn)
        timer_increment |-> $past(tclk_rise) && $past(count_en_nxt) && !$past(tclk_fall))
        else $error("increment not on rising edge");

    a_async_pass: assert property (@(posedge hclk) disable iff (!hresetn)
        !gate_cfg.timer_gate_source_select && !gate_cfg.comparator_sync_select
        |-> timer_gate == comparator_output)
        else $error("async comparator not passed");

    a_pin_route: assert property (@(posedge hclk) disable iff (!hresetn)
        gate_cfg.timer_gate_source_select |-> timer_gate == timer_gate_pin)
        else $error("gate pin not routed");

    a_cfg_b_upper: assert property (@(posedge hclk) disable iff (!hresetn)
        dp_read_r && dp_addr_r == cmp_pkg::CFG_B_OFFSET |-> hrdata[31:2] == 30'h0)
        else $error("config B upper bits not zero");

    a_gate_off: assert property (@(posedge hclk) disable iff (!hresetn)
        !timer_on |=> !timer_count_enable && !timer_increment)
        else $error("count while timer off");

    a_sync_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        timer_on && timer_gate_enable && !gate_cfg.timer_gate_source_select
        && gate_cfg.comparator_sync_select |=> timer_count_enable == $past(sync_latch_r))
        else $error("synced gate not from latch");

    a_incr_one_cycle: assert property (@(posedge hclk) disable iff (!hresetn)
        timer_increment |=> !timer_increment)
        else $error("increment wider than one cycle");

    a_fall_no_incr: assert property (@(posedge hclk) disable iff (!hresetn)
        tclk_fall |=> !timer_increment)
        else $error("increment on falling edge");

    a_unlatched_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !gate_cfg.comparator_sync_select |=> $stable(sync_latch_r))
        else $error("latch moved with sync off");

    a_cfg_b_unused: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg_b_r[7:2] == 6'h00)
        else $error("config B unused bits set");

    a_ungated_count: assert property (@(posedge hclk) disable iff (!hresetn)
        timer_on && !timer_gate_enable |=> timer_count_enable)
        else $error("ungated timer not enabled");

    a_pin_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        timer_on && timer_gate_enable && gate_cfg.timer_gate_source_select
        |=> timer_count_enable == $past(pin_lvl))
        else $error("pin gate not applied");

    a_raw_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        timer_on && timer_gate_enable && !gate_cfg.timer_gate_source_select
        && !gate_cfg.comparator_sync_select |=> timer_count_enable == $past(cmp_lvl))
        else $error("unsynced gate not from comparator");

    a_incr_enabled: assert property (@(posedge hclk) disable iff (!hresetn)
        timer_increment |-> timer_count_enable)
        else $error("increment without count enable");

    a_read_idle_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        !dp_read_r |-> hrdata == 32'h00000000)
        else $error("read data outside data phase");

endmodule

// *** verification/timer_far_end.sv ***
// Far-end timer model: clock source, prescaler and increment counter
`timescale 1ns/1ps
module timer_far_end (
    // Clock
    input  wire logic        hclk,
    // Bench controls
    input  wire logic        run,
    input  wire logic        raw_only,
    // Timer link
    input  wire logic        timer_increment,
    output logic             timer_clk_raw,
    output logic             timer_clk_prescaled,
    output logic [15:0]      inc_count
);
    logic [2:0]  phase_r = 3'h0;
    logic        raw_r   = 1'b1;
    logic        pre_r   = 1'b1;
    logic [15:0] count_r = 16'h0000;

    // Clocks stand still high between bursts, so every fall comes from a burst
    assign timer_clk_raw       = raw_r;
    assign timer_clk_prescaled = pre_r;
    assign inc_count           = count_r;

    // Half period of five hclk stays above the synchroniser's span
    always @(posedge hclk) begin
        phase_r <= (run && phase_r != 3'h4) ? phase_r + 3'h1 : 3'h0;
        if (run && phase_r == 3'h4) begin
            raw_r <= ~raw_r;
            if (!raw_r && !raw_only) begin
                pre_r <= ~pre_r; // Divide by two
            end
        end
        if (timer_increment === 1'b1) begin
            count_r <= count_r + 16'h0001;
        end
    end
endmodule

// *** verification/comparator_sync_and_reference_ctrl_bench.sv ***
// Self-checking bench for the comparator sync and reference control block
`timescale 1ns/1ps
module comparator_sync_and_reference_ctrl_bench;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, ladder_power, timer_gate, timer_count_enable, timer_increment;
    logic comparator_output = 1'b0, timer_prescale_on = 1'b0, timer_on = 1'b0;
    logic timer_gate_enable = 1'b0, timer_gate_pin = 1'b1, run = 1'b0, raw_only = 1'b0;
    logic timer_clk_raw, timer_clk_prescaled;
    logic [6:0] reference_code;
    logic [15:0] inc_count;
    cmp_pkg::cmp_cfg_t comparator_cfg;
    int err_total = 0, comparisons = 0;

    // 100 MHz clock
    always #5 hclk = ~hclk;

    comparator_sync_and_reference_ctrl DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .comparator_output(comparator_output), .comparator_cfg(comparator_cfg),
        .ladder_power(ladder_power), .reference_code(reference_code),
        .timer_clk_raw(timer_clk_raw), .timer_clk_prescaled(timer_clk_prescaled),
        .timer_prescale_on(timer_prescale_on), .timer_on(timer_on),
        .timer_gate_enable(timer_gate_enable), .timer_gate_pin(timer_gate_pin),
        .timer_gate(timer_gate), .timer_count_enable(timer_count_enable),
        .timer_increment(timer_increment));

    timer_far_end far_end (
        .hclk(hclk), .run(run), .raw_only(raw_only), .timer_increment(timer_increment),
        .timer_clk_raw(timer_clk_raw), .timer_clk_prescaled(timer_clk_prescaled),
        .inc_count(inc_count));

    task automatic tally_and_finish;
        if (err_total == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Bounded wait for hready sampled high at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin
            err_total++;
            tally_and_finish;
        end
    endtask

    // One single AHB-Lite word transfer; read data taken at the data phase edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'b1, a, {24'h0, d}, r);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        check(r, e);
        check(32'(hresp), 32'h0);
    endtask

    // Timer burst of four raw periods, then settle; negative skips the count check
    task automatic burst(input int exp_inc);
        logic [15:0] c0;
        c0 = inc_count;
        run <= 1'b1;
        repeat (40) @(posedge hclk);
        run <= 1'b0;
        repeat (12) @(posedge hclk);
        if (exp_inc >= 0) check(32'(inc_count - c0), 32'(exp_inc));
    endtask

    task automatic gchk(input logic e);
        @(negedge hclk);
        check(32'(timer_gate), 32'(e));
        @(posedge hclk);
    endtask

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        gchk(1'b1);
        rchk(8'h00, 32'h00);
        rchk(8'h04, 32'h02);
        rchk(8'h08, 32'h00);
        wr(8'h04, 8'hFF);
        rchk(8'h04, 32'h03);
        wr(8'h08, 8'hFF);
        rchk(8'h08, 32'hAF);
        wr(8'h00, 8'hFF);
        rchk(8'h00, 32'h1F);
        rchk(8'h0C, 32'h00);
        // Low and high range taps in 1/96 of the supply
        for (int i = 0; i < 4; i++) begin
            wr(8'h08, 8'hA0 | 8'(i * 5));
            repeat (3) @(posedge hclk);
            check(32'(reference_code), 32'(i * 20));
            check(32'(ladder_power), 32'h1);
            wr(8'h08, 8'h80 | 8'(i * 5));
            repeat (3) @(posedge hclk);
            check(32'(reference_code), 32'(24 + i * 15));
        end
        wr(8'h00, 8'h07);
        repeat (3) @(posedge hclk);
        check(32'(reference_code), 32'(69));
        check(32'(comparator_cfg), 32'h07);
        wr(8'h08, 8'h20);
        repeat (3) @(posedge hclk);
        check({24'h0, ladder_power, reference_code}, 32'h0);
        // Gate pin routed
        wr(8'h04, 8'h02);
        timer_gate_pin <= 1'b0;
        gchk(1'b0);
        // Raw comparator routed, unlatched
        wr(8'h04, 8'h00);
        comparator_output <= 1'b1;
        gchk(1'b1);
        comparator_output <= 1'b0;
        gchk(1'b0);
        // Sync on: value only moves on a falling timer clock
        wr(8'h04, 8'h01);
        burst(-1);
        comparator_output <= 1'b1;
        repeat (10) @(posedge hclk);
        gchk(1'b0);
        burst(-1);
        gchk(1'b1);
        timer_prescale_on <= 1'b1;
        raw_only <= 1'b1;
        comparator_output <= 1'b0;
        burst(-1);
        gchk(1'b1);
        raw_only <= 1'b0;
        burst(-1);
        gchk(1'b0);
        // Increment counts
        timer_on <= 1'b1;
        burst(2);
        timer_prescale_on <= 1'b0;
        burst(4);
        timer_gate_enable <= 1'b1;
        wr(8'h04, 8'h02);
        repeat (8) @(posedge hclk);
        burst(0);
        check(32'(timer_count_enable), 32'h0);
        timer_gate_pin <= 1'b1;
        repeat (8) @(posedge hclk);
        check(32'(timer_count_enable), 32'h1);
        burst(4);
        wr(8'h04, 8'h01);
        comparator_output <= 1'b1;
        burst(-1);
        burst(4);
        // Comparator drops with no timer clock: the latched gate keeps counting enabled
        comparator_output <= 1'b0;
        repeat (8) @(posedge hclk);
        check(32'(timer_count_enable), 32'h1);
        gchk(1'b1);
        wr(8'h04, 8'h00);
        repeat (3) @(posedge hclk);
        check(32'(timer_count_enable), 32'h0);
        timer_on <= 1'b0;
        burst(0);
        // Reset in mid-run restores the register reset values
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(8'h00, 32'h00);
        rchk(8'h04, 32'h02);
        rchk(8'h08, 32'h00);
        check(32'(ladder_power), 32'h0);
        tally_and_finish;
    end
endmodule
